// ==== logic/adc_seq_pkg.sv ====
// Purpose: Shared constants and types for the serial converter frame sequencer.
// Assumes: One 125 MHz system clock; all pin inputs asynchronous to it.
// Notes: Conversion timing is an internal count, shortened through module parameters.
package adc_seq_pkg;
  localparam int CMD_BITS = 8;
  localparam int ADDR_BITS = 4;
  localparam int CFG_BITS = 4;
  localparam int RESULT_BITS = 12;
  localparam int EDGE_CNT_BITS = 5;
  localparam logic [EDGE_CNT_BITS-1:0] FRAME_EDGES = 5'h0C;
  localparam logic [EDGE_CNT_BITS-1:0] ADDR_EDGE = 5'h04;
  localparam logic [EDGE_CNT_BITS-1:0] SAMPLE_EDGE = 5'h04;
  localparam logic [EDGE_CNT_BITS-1:0] CMD_EDGE = 5'h08;
  localparam int CONV_DIV_DEF = 4;
  localparam int CONV_TICKS_DEF = 40;
  localparam int CONV_CNT_BITS = 16;
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 12'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FRAME = 2'b01,
    ST_CONVERT = 2'b10
  } seq_state_e;

  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic din;
  } pins_s;

  typedef struct packed {
    logic [ADDR_BITS-1:0] channel;
    logic [CFG_BITS-1:0] config_bits;
  } cmd_word_s;
endpackage : adc_seq_pkg

// ==== logic/serial_adc_frame_sequencer.sv ====
// Purpose: Frame sequencing for a serial successive-approximation converter.
// Assumes: Serial clock is much slower than clk_in so every edge is seen after sync.
// Notes: The analog result arrives on result_in and is taken at end of conversion.
`timescale 1ns/1ps

// Behaviour
// - After the last serial clock falling edge, the done flag drops low.
// - Done flag stays low during conversion, rises when result is ready.
// - Eight serial_in bits captured on the first eight rising edges.
// - Channel address applied to input selection after the fourth rising edge.
// - Sampling starts at the fourth falling edge, ends at the last falling edge.
// - Remaining eleven result bits shift out after the first bit.
// - serial_out changes only on falling serial clock edges and at the select falling edge.
// - Last falling edge hands conversion to the internal controller.
// - Select falling edge resets counters and control, enables the serial pins.
// - serial_out is released while select is high, driven while low.
// - At select low, the first result bit appears at once, per bit order.
module serial_adc_frame_sequencer
  import adc_seq_pkg::*;
#(
  parameter int CONV_DIV = CONV_DIV_DEF,
  parameter int CONV_TICKS = CONV_TICKS_DEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic select_n_in,
  input wire logic sclk_in,
  input wire logic serial_in,
  input wire logic lsb_first_in,
  input wire logic [RESULT_BITS-1:0] result_in,
  output logic serial_out,
  output logic serial_oe_out,
  output logic conversion_done_flag_out,
  output logic sampling_out,
  output logic conv_start_out,
  output logic [ADDR_BITS-1:0] channel_out,
  output cmd_word_s command_register_out
);
  localparam int CONV_LEN = CONV_DIV * CONV_TICKS;
  localparam logic [CONV_CNT_BITS-1:0] DIV_LAST = CONV_CNT_BITS'(CONV_DIV - 1);
  localparam logic [CONV_CNT_BITS-1:0] TICK_LAST = CONV_CNT_BITS'(CONV_TICKS - 1);

  pins_s sync1_q, sync2_q, prev_q;
  seq_state_e state_q, state_d;
  logic [EDGE_CNT_BITS-1:0] rise_cnt_q, rise_cnt_d, fall_cnt_q, fall_cnt_d;
  logic [CMD_BITS-1:0] cmd_sh_q, cmd_sh_d;
  cmd_word_s command_q, command_d;
  logic [ADDR_BITS-1:0] channel_q, channel_d;
  logic [RESULT_BITS-1:0] out_sh_q, out_sh_d, result_q, result_d;
  logic serial_q, serial_d, oe_q, oe_d, done_q, done_d;
  logic sampling_q, sampling_d, start_q, start_d, lsb_q, lsb_d;
  logic [CONV_CNT_BITS-1:0] div_q, div_d, tick_cnt_q, tick_cnt_d;
  logic sel_fall, sel_rise, sc_rise, sc_fall, in_frame, last_fall, conv_tick;

  // Edge detection reads only the second synchroniser stage and its delayed copy.
  assign sel_fall = prev_q.sel_n & ~sync2_q.sel_n;
  assign sel_rise = ~prev_q.sel_n & sync2_q.sel_n;
  assign in_frame = (state_q == ST_FRAME) & ~sync2_q.sel_n;
  assign sc_rise = in_frame & ~prev_q.sclk & sync2_q.sclk;
  assign sc_fall = in_frame & prev_q.sclk & ~sync2_q.sclk;
  assign last_fall = sc_fall & (fall_cnt_q == FRAME_EDGES - 5'h01);
  assign conv_tick = (state_q == ST_CONVERT) & (div_q == DIV_LAST);

  always_comb begin
    state_d = state_q;
    rise_cnt_d = rise_cnt_q;
    fall_cnt_d = fall_cnt_q;
    cmd_sh_d = cmd_sh_q;
    command_d = command_q;
    channel_d = channel_q;
    out_sh_d = out_sh_q;
    result_d = result_q;
    serial_d = serial_q;
    oe_d = ~sync2_q.sel_n;
    done_d = done_q;
    sampling_d = sampling_q;
    start_d = 1'b0;
    lsb_d = lsb_q;
    div_d = div_q;
    tick_cnt_d = tick_cnt_q;
    if (sel_fall) begin
      state_d = ST_FRAME;
      rise_cnt_d = '0;
      fall_cnt_d = '0;
      cmd_sh_d = '0;
      sampling_d = 1'b0;
      lsb_d = lsb_first_in;
      out_sh_d = result_q;
      serial_d = lsb_first_in ? result_q[0] : result_q[RESULT_BITS-1];
    end else if (state_q == ST_FRAME) begin
      // A frame cut short by select returns to idle without converting.
      if (sel_rise) begin
        state_d = ST_IDLE;
        sampling_d = 1'b0;
      end
      if (sc_rise && rise_cnt_q < CMD_EDGE) begin
        cmd_sh_d = {cmd_sh_q[CMD_BITS-2:0], sync2_q.din};
        rise_cnt_d = rise_cnt_q + 5'h01;
        if (rise_cnt_q == ADDR_EDGE - 5'h01) begin
          channel_d = {cmd_sh_q[ADDR_BITS-2:0], sync2_q.din};
        end
        if (rise_cnt_q == CMD_EDGE - 5'h01) begin
          command_d = cmd_word_s'({cmd_sh_q[CMD_BITS-2:0], sync2_q.din});
        end
      end
      if (sc_fall) begin
        fall_cnt_d = fall_cnt_q + 5'h01;
        if (lsb_q) begin
          out_sh_d = {1'b0, out_sh_q[RESULT_BITS-1:1]};
          serial_d = out_sh_q[1];
        end else begin
          out_sh_d = {out_sh_q[RESULT_BITS-2:0], 1'b0};
          serial_d = out_sh_q[RESULT_BITS-2];
        end
        if (fall_cnt_q == SAMPLE_EDGE - 5'h01) begin
          sampling_d = 1'b1;
        end
        if (last_fall) begin
          sampling_d = 1'b0;
          state_d = ST_CONVERT;
          start_d = 1'b1;
          div_d = '0;
          tick_cnt_d = '0;
          done_d = 1'b0;
        end
      end
    end else if (state_q == ST_CONVERT) begin
      div_d = conv_tick ? '0 : div_q + 16'h0001;
      if (conv_tick) begin
        tick_cnt_d = tick_cnt_q + 16'h0001;
        if (tick_cnt_q == TICK_LAST) begin
          done_d = 1'b1;
          result_d = result_in;
          state_d = ST_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= '{sel_n: 1'b1, sclk: 1'b0, din: 1'b0};
      sync2_q <= '{sel_n: 1'b1, sclk: 1'b0, din: 1'b0};
      prev_q <= '{sel_n: 1'b1, sclk: 1'b0, din: 1'b0};
      state_q <= ST_IDLE;
      rise_cnt_q <= '0;
      fall_cnt_q <= '0;
      cmd_sh_q <= '0;
      command_q <= '0;
      channel_q <= '0;
      out_sh_q <= RESULT_RESET;
      result_q <= RESULT_RESET;
      serial_q <= 1'b0;
      oe_q <= 1'b0;
      done_q <= 1'b1;
      sampling_q <= 1'b0;
      start_q <= 1'b0;
      lsb_q <= 1'b0;
      div_q <= '0;
      tick_cnt_q <= '0;
    end else begin
      sync1_q <= '{sel_n: select_n_in, sclk: sclk_in, din: serial_in};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      state_q <= state_d;
      rise_cnt_q <= rise_cnt_d;
      fall_cnt_q <= fall_cnt_d;
      cmd_sh_q <= cmd_sh_d;
      command_q <= command_d;
      channel_q <= channel_d;
      out_sh_q <= out_sh_d;
      result_q <= result_d;
      serial_q <= serial_d;
      oe_q <= oe_d;
      done_q <= done_d;
      sampling_q <= sampling_d;
      start_q <= start_d;
      lsb_q <= lsb_d;
      div_q <= div_d;
      tick_cnt_q <= tick_cnt_d;
    end
  end

  assign serial_out = serial_q;
  assign serial_oe_out = oe_q;
  assign conversion_done_flag_out = done_q;
  assign sampling_out = sampling_q;
  assign conv_start_out = start_q;
  assign channel_out = channel_q;
  assign command_register_out = command_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence final_edge_s;
    last_fall ##1 (state_q == ST_CONVERT);
  endsequence

  sequence conv_window_s;
    $fell(done_q) ##CONV_LEN $rose(done_q);
  endsequence

  eoc_fall_a: assert property (final_edge_s |-> !conversion_done_flag_out)
    else $error("done flag not low after last falling edge");
  eoc_busy_a: assert property ((state_q == ST_CONVERT) |-> !conversion_done_flag_out)
    else $error("done flag high during conversion");
  conv_length_a: assert property ($fell(done_q) && !sel_fall |-> conv_window_s)
    else $error("conversion length wrong");
  cmd_capture_a: assert property (sc_rise && !sel_fall && rise_cnt_q == CMD_EDGE - 5'h01
      |=> command_q == {$past(cmd_sh_q[CMD_BITS-2:0]), $past(sync2_q.din)})
    else $error("command word not captured on eighth rising edge");
  chan_apply_a: assert property (sc_rise && !sel_fall && rise_cnt_q == ADDR_EDGE - 5'h01
      |=> channel_out == {$past(cmd_sh_q[ADDR_BITS-2:0]), $past(sync2_q.din)})
    else $error("channel not applied after fourth rising edge");
  sample_start_a: assert property (sc_fall && !sel_fall && fall_cnt_q == SAMPLE_EDGE - 5'h01
      |=> sampling_out)
    else $error("sampling not started on fourth falling edge");
  sample_end_a: assert property (final_edge_s |-> !sampling_out && conv_start_out)
    else $error("sampling or hand-over wrong at last falling edge");
  dout_edge_a: assert property ($changed(serial_q) |-> $past(sc_fall) || $past(sel_fall))
    else $error("serial_out changed off a falling edge");
  oe_follow_a: assert property (sync2_q.sel_n |=> !serial_oe_out)
    else $error("serial_out driven while deselected");
  first_bit_a: assert property (sel_fall |=> serial_out
      == (lsb_q ? result_q[0] : result_q[RESULT_BITS-1]) && state_q == ST_FRAME
      && rise_cnt_q == '0 && fall_cnt_q == '0)
    else $error("frame start did not reset or present first bit");
  shift_count_a: assert property (sc_fall && !sel_fall && fall_cnt_q < FRAME_EDGES
      |=> fall_cnt_q == $past(fall_cnt_q) + 5'h01)
    else $error("falling edge count did not advance");
endmodule : serial_adc_frame_sequencer

// ==== verif/adc_host_model.sv ====
// Purpose: Host serial port model that runs frames of a given pulse count (12 for a full frame) against the sequencer.
// Assumes: Serial clock idles low and stands still outside frames.
// Notes: Data is sampled just before each falling edge, well after it has settled.
`timescale 1ns/1ps
module adc_host_model
  import adc_seq_pkg::*;
(
  input wire logic clk_in,
  input wire logic data_in,
  input wire logic done_in,
  output logic select_n_out = 1'b1,
  output logic sclk_out = 1'b0,
  output logic din_out = 1'b0
);
  task automatic frame(input cmd_word_s cmd, input int pulses, output logic [11:0] got);
    int i;
    int n;
    @(negedge clk_in);
    select_n_out = 1'b0;
    repeat (8) @(negedge clk_in);
    for (i = 0; i < pulses; i++) begin
      din_out = (i < 8) ? cmd[7-i] : ~din_out;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (3) @(negedge clk_in);
      got = {got[10:0], data_in};
      @(negedge clk_in);
      sclk_out = 1'b0;
    end
    repeat (8) @(negedge clk_in);
    for (n = 0; pulses == 12 && done_in !== 1'b1 && n < 200; n++) @(negedge clk_in);
    select_n_out = 1'b1;
    // The data line toggles between frames, so stale values cannot pass.
    repeat (6) begin
      @(negedge clk_in);
      din_out = ~din_out;
    end
  endtask : frame
endmodule : adc_host_model

// ==== verif/serial_adc_frame_sequencer_tb.sv ====
// Purpose: Self-checking bench for the serial converter frame sequencer.
// Assumes: Short conversion parameters; 64 ns serial clock from the host model.
// Notes: Frame 3 is cut after five pulses to exercise the restart path.
`timescale 1ns/1ps
module serial_adc_frame_sequencer_tb;
  import adc_seq_pkg::*;
  localparam int DIV = 2;
  localparam int TICKS = 3;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic lsb_first_in = 1'b0;
  logic [RESULT_BITS-1:0] result_in = 12'h000;
  logic select_n_in, sclk_in, serial_in, serial_out, serial_oe_out, eoc, sampling_out;
  logic conv_start_out;
  logic [ADDR_BITS-1:0] channel_out;
  logic [ADDR_BITS-1:0] prev_ch = 4'h0;
  cmd_word_s command_register_out;
  cmd_word_s cur;
  cmd_word_s exp_q[$];
  int mismatches = 0;
  int n_tests = 0;
  int rises = 0;
  int lowc = 0;

  serial_adc_frame_sequencer #(.CONV_DIV(DIV), .CONV_TICKS(TICKS)) i_dut (
    .clk_in, .rst_in, .select_n_in, .sclk_in, .serial_in, .lsb_first_in, .result_in,
    .serial_out, .serial_oe_out, .conversion_done_flag_out(eoc), .sampling_out,
    .conv_start_out, .channel_out, .command_register_out
  );
  adc_host_model i_host (
    .clk_in, .data_in(serial_oe_out ? serial_out : ~serial_out), .done_in(eoc),
    .select_n_out(select_n_in),
    .sclk_out(sclk_in), .din_out(serial_in)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  initial forever #4 clk_in = ~clk_in;
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    report_and_stop();
  end

  always @(negedge select_n_in) rises = 0;
  always @(posedge sclk_in) begin
    rises++;
    check(serial_oe_out, 1'b1, "oe in frame");
    check(eoc, 1'b1, "done idle");
    check(sampling_out, rises >= 5, "sampling window");
    if (rises == 4) check(channel_out, prev_ch, "channel early");
    if (rises == 5) check(channel_out, cur.channel, "channel");
  end

  // Notes are taken off the queue as each conversion starts.
  always @(negedge clk_in) begin
    if (conv_start_out === 1'b1) begin
      check(exp_q.size() > 0, 1'b1, "stray conversion");
      if (exp_q.size() > 0) check(command_register_out, exp_q.pop_front(), "command");
      check(eoc, 1'b0, "done fall");
      check(sampling_out, 1'b0, "sampling end");
    end
    if (eoc === 1'b0) lowc++;
    else if (lowc > 0) begin
      check(16'(lowc), 16'(DIV * TICKS), "conversion length");
      lowc = 0;
    end
  end

  initial begin
    logic [11:0] prev, res, got, exp;
    logic lsb;
    int i, j;
    prev = RESULT_RESET;
    void'($urandom(32'h84794ECA));
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check(serial_oe_out, 1'b0, "oe idle");
    for (i = 0; i < 8; i++) begin
      cur = cmd_word_s'(8'($urandom));
      res = 12'($urandom);
      lsb = 1'($urandom);
      lsb_first_in = lsb;
      result_in = res;
      if (i != 3) exp_q.push_back(cur);
      fork
        i_host.frame(cur, (i == 3) ? 5 : 12, got);
        begin
          repeat (20) @(negedge clk_in);
          lsb_first_in = ~lsb;
        end
      join
      for (j = 0; j < 12; j++) exp[11-j] = lsb ? prev[j] : prev[11-j];
      if (i != 3) begin
        check(got, exp, "result word");
        check(eoc, 1'b1, "done raised");
        prev = res;
      end
      prev_ch = cur.channel;
      check(serial_oe_out, 1'b0, "oe released");
      $display("frame %0d done", i);
    end
    check(16'(exp_q.size()), 16'h0000, "missing conversion");
    report_and_stop();
  end
endmodule : serial_adc_frame_sequencer_tb
